/* File: rtl/fld_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
module fld_decoder #(
    parameter int unsigned XLEN = 32
) (
    input wire logic mclk_i, // processor clock
    input wire logic reset_i, // synchronous, active high
    input wire logic insn_valid_i, // fetch presents a word
    input wire logic [fld_pkg::INSN_W-1:0] insn_i, // instruction word
    output logic dec_valid_o, // decoded fields valid
    output logic illegal_o, // word matched no pattern
    output fld_pkg::fld_fmt_t fmt_o, // instruction format
    output fld_pkg::fld_mode_t src_mode_o, // source operand role
    output fld_pkg::fld_mode_t dest_mode_o, // destination operand role
    output logic [3:0] dest_reg_o, // destination register number
    output logic [3:0] src_reg_o, // source register number
    output logic [fld_pkg::DISP_W-1:0] disp_o, // raw displacement
    output logic [XLEN-1:0] imm_o, // extended immediate
    output logic [fld_pkg::TRAP_W-1:0] trap_vec_o, // trap vector offset
    output logic [2:0] step_o // post-inc / pre-dec amount
);
    if (XLEN < fld_pkg::IMM_W) $error("XLEN too narrow for the immediate");

    logic [3:0] fn, fm, f4;
    logic [7:0] f8;
    logic legal, sext;
    fld_pkg::fld_fmt_t fmt;
    fld_pkg::fld_mode_t smode, dmode;
    logic [3:0] dreg, sreg;
    logic [fld_pkg::DISP_W-1:0] disp;
    logic [2:0] step;
    logic use_imm;
    logic next_valid, next_illegal;
    fld_pkg::fld_fmt_t next_fmt;
    fld_pkg::fld_mode_t next_smode, next_dmode;
    logic [3:0] next_dreg, next_sreg;
    logic [fld_pkg::DISP_W-1:0] next_disp;
    logic [XLEN-1:0] next_imm;
    logic [fld_pkg::TRAP_W-1:0] next_trap;
    logic [2:0] next_step;

    function automatic logic [2:0] size_step(input logic [1:0] sz);
        case (sz)
            2'h0: size_step = fld_pkg::STEP_BYTE;
            2'h1: size_step = fld_pkg::STEP_WORD;
            default: size_step = fld_pkg::STEP_LONG;
        endcase
    endfunction

    assign fn = insn_i[fld_pkg::N_HI:fld_pkg::N_LO];
    assign fm = insn_i[fld_pkg::M_HI:fld_pkg::M_LO];
    assign f4 = insn_i[fld_pkg::D4_HI:0];
    assign f8 = insn_i[fld_pkg::D8_HI:0];

    // format and operand-role decode
    always_comb
    begin
        legal = 1'b1;
        sext = 1'b0;
        use_imm = 1'b0;
        fmt = fld_pkg::FMT_NONE;
        smode = fld_pkg::MODE_NONE;
        dmode = fld_pkg::MODE_NONE;
        dreg = 4'h0;
        sreg = 4'h0;
        disp = '0;
        step = fld_pkg::STEP_NONE;
        case (insn_i[fld_pkg::OP_HI:fld_pkg::OP_LO])
            4'h0:
            begin
                if (insn_i inside {16'h0009, 16'h0008, 16'h0018, 16'h0028, 16'h000b, 16'h002b,
                                   16'h001b, 16'h0019})
                begin
                    fmt = fld_pkg::FMT_ZERO;
                end
                else if (f8 inside {8'h29, 8'h02, 8'h12, 8'h22, 8'h0a, 8'h1a, 8'h2a})
                begin
                    fmt = fld_pkg::FMT_N;
                    dreg = fn;
                    dmode = fld_pkg::MODE_DIRECT;
                    smode = (f8 == 8'h29) ? fld_pkg::MODE_NONE : fld_pkg::MODE_CTRL_SYS;
                end
                else if (f4 inside {4'h4, 4'h5, 4'h6})
                begin
                    fmt = fld_pkg::FMT_NM;
                    dreg = fn;
                    sreg = fm;
                    smode = fld_pkg::MODE_DIRECT;
                    dmode = fld_pkg::MODE_ZERO_INDEXED;
                end
                else if (f4 inside {4'hc, 4'hd, 4'he})
                begin
                    fmt = fld_pkg::FMT_NM;
                    dreg = fn;
                    sreg = fm;
                    smode = fld_pkg::MODE_ZERO_INDEXED;
                    dmode = fld_pkg::MODE_DIRECT;
                end
                else
                begin
                    legal = 1'b0;
                end
            end
            4'h1, 4'h5:
            begin
                fmt = fld_pkg::FMT_NMD;
                dreg = fn;
                sreg = fm;
                disp = {8'h00, f4};
                step = fld_pkg::STEP_NONE;
                smode = insn_i[14] ? fld_pkg::MODE_DISP : fld_pkg::MODE_DIRECT;
                dmode = insn_i[14] ? fld_pkg::MODE_DIRECT : fld_pkg::MODE_DISP;
            end
            4'h2, 4'h3, 4'h6:
            begin
                fmt = fld_pkg::FMT_NM;
                dreg = fn;
                sreg = fm;
                smode = fld_pkg::MODE_DIRECT;
                dmode = fld_pkg::MODE_DIRECT;
                if (insn_i[14:12] == 3'h3 && f4 inside {4'h1, 4'h5, 4'h9, 4'hd})
                begin
                    legal = 1'b0;
                end
                else if (insn_i[14:12] == 3'h2 && f4 == 4'h3)
                begin
                    legal = 1'b0;
                end
                else if (insn_i[14:12] == 3'h2 && f4 inside {4'h0, 4'h1, 4'h2})
                begin
                    dmode = fld_pkg::MODE_INDIRECT;
                end
                else if (insn_i[14:12] == 3'h2 && f4 inside {4'h4, 4'h5, 4'h6})
                begin
                    dmode = fld_pkg::MODE_PREDEC;
                    step = size_step(f4[1:0]);
                end
                else if (insn_i[14] && f4 inside {4'h0, 4'h1, 4'h2})
                begin
                    smode = fld_pkg::MODE_INDIRECT;
                end
                else if (insn_i[14] && f4 inside {4'h4, 4'h5, 4'h6})
                begin
                    smode = fld_pkg::MODE_POSTINC;
                    step = size_step(f4[1:0]);
                end
            end
            4'h4:
            begin
                dreg = fn;
                sreg = fn;
                if (f4 == 4'hf)
                begin
                    fmt = fld_pkg::FMT_NM;
                    sreg = fm;
                    smode = fld_pkg::MODE_POSTINC;
                    dmode = fld_pkg::MODE_ACCUM;
                    step = fld_pkg::STEP_WORD;
                end
                else if (f8 inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h18, 8'h19, 8'h28,
                                    8'h29, 8'h20, 8'h21, 8'h24, 8'h25, 8'h11, 8'h15, 8'h1b})
                begin
                    fmt = fld_pkg::FMT_N;
                    dmode = (f8 == 8'h1b) ? fld_pkg::MODE_INDIRECT : fld_pkg::MODE_DIRECT;
                    sreg = 4'h0;
                end
                else if (f8 inside {8'h03, 8'h13, 8'h23, 8'h02, 8'h12, 8'h22})
                begin
                    fmt = fld_pkg::FMT_N;
                    sreg = 4'h0;
                    smode = fld_pkg::MODE_CTRL_SYS;
                    dmode = fld_pkg::MODE_PREDEC;
                    step = fld_pkg::STEP_LONG;
                end
                else if (f8 inside {8'h0e, 8'h1e, 8'h2e, 8'h0a, 8'h1a, 8'h2a, 8'h07, 8'h17, 8'h27,
                                    8'h06, 8'h16, 8'h26})
                begin
                    fmt = fld_pkg::FMT_M;
                    dreg = 4'h0;
                    dmode = fld_pkg::MODE_CTRL_SYS;
                    smode = f4[3] ? fld_pkg::MODE_DIRECT : fld_pkg::MODE_POSTINC;
                    step = f4[3] ? fld_pkg::STEP_NONE : fld_pkg::STEP_LONG;
                end
                else if (f8 inside {8'h2b, 8'h0b})
                begin
                    fmt = fld_pkg::FMT_M;
                    dreg = 4'h0;
                    smode = fld_pkg::MODE_DIRECT;
                end
                else
                begin
                    legal = 1'b0;
                end
            end
            4'h7, 4'he:
            begin
                fmt = fld_pkg::FMT_NI;
                dreg = fn;
                smode = fld_pkg::MODE_IMM;
                dmode = fld_pkg::MODE_DIRECT;
                use_imm = 1'b1;
                sext = 1'b1;
            end
            4'h8:
            begin
                if (fn inside {4'h0, 4'h1})
                begin
                    fmt = fld_pkg::FMT_ND4;
                    dreg = fm;
                    disp = {8'h00, f4};
                    smode = fld_pkg::MODE_ZERO_REG;
                    dmode = fld_pkg::MODE_DISP;
                end
                else if (fn inside {4'h4, 4'h5})
                begin
                    fmt = fld_pkg::FMT_MD;
                    sreg = fm;
                    disp = {8'h00, f4};
                    smode = fld_pkg::MODE_DISP;
                    dmode = fld_pkg::MODE_ZERO_REG;
                end
                else if (fn == 4'h8)
                begin
                    fmt = fld_pkg::FMT_I;
                    smode = fld_pkg::MODE_IMM;
                    dmode = fld_pkg::MODE_ZERO_REG;
                    use_imm = 1'b1;
                    sext = 1'b1;
                end
                else if (fn inside {4'h9, 4'hb})
                begin
                    fmt = fld_pkg::FMT_D;
                    disp = {4'h0, f8};
                    smode = fld_pkg::MODE_PC_REL;
                end
                else
                begin
                    legal = 1'b0;
                end
            end
            4'h9, 4'hd:
            begin
                fmt = fld_pkg::FMT_ND8;
                dreg = fn;
                disp = {4'h0, f8};
                smode = fld_pkg::MODE_PC_REL;
                dmode = fld_pkg::MODE_DIRECT;
            end
            4'ha, 4'hb:
            begin
                fmt = fld_pkg::FMT_D12;
                disp = insn_i[fld_pkg::D12_HI:0];
                smode = fld_pkg::MODE_PC_REL;
            end
            4'hc:
            begin
                if (fn == 4'h3 || fn[3])
                begin
                    fmt = fld_pkg::FMT_I;
                    smode = fld_pkg::MODE_IMM;
                    use_imm = 1'b1;
                    if (fn[3])
                    begin
                        dmode = fn[2] ? fld_pkg::MODE_GBR_INDEXED : fld_pkg::MODE_ZERO_REG;
                    end
                end
                else
                begin
                    fmt = fld_pkg::FMT_D;
                    disp = {4'h0, f8};
                    if (fn == 4'h7)
                    begin
                        smode = fld_pkg::MODE_PC_REL;
                        dmode = fld_pkg::MODE_ZERO_REG;
                    end
                    else
                    begin
                        smode = fn[2] ? fld_pkg::MODE_GBR_DISP : fld_pkg::MODE_ZERO_REG;
                        dmode = fn[2] ? fld_pkg::MODE_ZERO_REG : fld_pkg::MODE_GBR_DISP;
                    end
                end
            end
            default:
            begin
                legal = 1'b0;
            end
        endcase
    end

    // gating: bubbles and illegal words carry no fields
    always_comb
    begin
        next_valid = insn_valid_i && legal;
        next_illegal = insn_valid_i && !legal;
        next_fmt = next_valid ? fmt : fld_pkg::FMT_NONE;
        next_smode = next_valid ? smode : fld_pkg::MODE_NONE;
        next_dmode = next_valid ? dmode : fld_pkg::MODE_NONE;
        next_dreg = next_valid ? dreg : 4'h0;
        next_sreg = next_valid ? sreg : 4'h0;
        next_disp = next_valid ? disp : '0;
        next_step = next_valid ? step : fld_pkg::STEP_NONE;
        next_imm = '0;
        next_trap = '0;
        if (next_valid && use_imm)
        begin
            next_imm = {{(XLEN-fld_pkg::IMM_W){sext & f8[7]}}, f8};
        end
        if (next_valid && insn_i[fld_pkg::OP_HI:fld_pkg::N_LO] == 8'hc3)
        begin
            next_trap = {f8, {fld_pkg::TRAP_SHIFT{1'b0}}};
            next_dmode = fld_pkg::MODE_NONE;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            dec_valid_o <= 1'b0;
            illegal_o <= 1'b0;
            fmt_o <= fld_pkg::FMT_NONE;
            src_mode_o <= fld_pkg::MODE_NONE;
            dest_mode_o <= fld_pkg::MODE_NONE;
            dest_reg_o <= 4'h0;
            src_reg_o <= 4'h0;
            disp_o <= '0;
            imm_o <= '0;
            trap_vec_o <= '0;
            step_o <= fld_pkg::STEP_NONE;
        end
        else
        begin
            dec_valid_o <= next_valid;
            illegal_o <= next_illegal;
            fmt_o <= next_fmt;
            src_mode_o <= next_smode;
            dest_mode_o <= next_dmode;
            dest_reg_o <= next_dreg;
            src_reg_o <= next_sreg;
            disp_o <= next_disp;
            imm_o <= next_imm;
            trap_vec_o <= next_trap;
            step_o <= next_step;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    nop_zero_fmt_a: assert property (insn_valid_i && insn_i == 16'h0009 |=> fmt_o == fld_pkg::FMT_ZERO
        && src_mode_o == fld_pkg::MODE_NONE && dest_mode_o == fld_pkg::MODE_NONE && disp_o == '0)
        else $error("no-operation word produced operand fields");
    ni_fields_a: assert property (insn_valid_i && insn_i[15:12] == 4'h7 |=> fmt_o == fld_pkg::FMT_NI
        && dest_reg_o == $past(insn_i[11:8]) && imm_o[7:0] == $past(insn_i[7:0])
        && imm_o[XLEN-1] == $past(insn_i[7]))
        else $error("register-immediate fields wrong");
    logic_zext_a: assert property (insn_valid_i && insn_i[15:10] == 6'h32 |=> imm_o[XLEN-1:8] == '0
        && imm_o[7:0] == $past(insn_i[7:0]))
        else $error("logic immediate not zero-extended");
    trap_vec_a: assert property (insn_valid_i && insn_i[15:8] == 8'hc3 |=>
        trap_vec_o == {$past(insn_i[7:0]), 2'h0} && dest_mode_o == fld_pkg::MODE_NONE)
        else $error("trap vector offset wrong");
    d12_disp_a: assert property (insn_valid_i && insn_i[15:13] == 3'h5 |=> fmt_o == fld_pkg::FMT_D12
        && disp_o == $past(insn_i[11:0]) && src_mode_o == fld_pkg::MODE_PC_REL)
        else $error("12-bit displacement wrong");
    mac_postinc_a: assert property (insn_valid_i && insn_i[15:12] == 4'h4 && insn_i[3:0] == 4'hf |=>
        src_mode_o == fld_pkg::MODE_POSTINC && dest_mode_o == fld_pkg::MODE_ACCUM
        && step_o == fld_pkg::STEP_WORD && dest_reg_o == $past(insn_i[11:8]))
        else $error("multiply-accumulate roles wrong");
    predec_step_a: assert property (insn_valid_i && insn_i[15:12] == 4'h2 && insn_i[3:0] == 4'h6 |=>
        dest_mode_o == fld_pkg::MODE_PREDEC && step_o == fld_pkg::STEP_LONG)
        else $error("pre-decrement step wrong");
    illegal_flag_a: assert property (insn_valid_i && insn_i[15:12] == 4'hf |=> illegal_o && !dec_valid_o
        && fmt_o == fld_pkg::FMT_NONE && imm_o == '0)
        else $error("illegal word not flagged");
    bubble_quiet_a: assert property (!insn_valid_i |=> !dec_valid_o && !illegal_o)
        else $error("output valid without an input word");

    ni_seen_c: cover property (insn_valid_i && insn_i[15:12] == 4'he ##1 dec_valid_o);
    trap_seen_c: cover property (insn_valid_i && insn_i[15:8] == 8'hc3 ##1 trap_vec_o != '0);
    illegal_seen_c: cover property (illegal_o ##1 dec_valid_o);
    mac_seen_c: cover property (dest_mode_o == fld_pkg::MODE_ACCUM);
endmodule
`default_nettype wire

/* File: rtl/fld_pkg.sv */
// Behaviour
// - every word 16 bits; zero format extracts nothing
// - n format: bits 11:8 destination register
// - n format: control/system store, direct or pre-decrement destination
// - m format: bits 11:8 source register, jumps
// - m format: control load, direct or post-increment
// - nm format: 11:8 destination, 7:4 source, modes
// - multiply-accumulate: source post-increment, accumulator destination
// - md format: 7:4 base, 3:0 displacement, zero register
// - nd4 format: 7:4 base, 3:0 displacement, store
// - nmd format: n, m, 4-bit displacement, both directions
// - d format: 8-bit displacement, base or pc relative
// - d12 format: 12-bit pc-relative displacement
// - nd8 format: destination plus pc-relative displacement
// - i format: 8-bit immediate, indexed or zero register
// - ni format: destination plus 8-bit immediate
// - sign-extend move/add/compare, zero-extend logic ops
// - trap immediate zero-extended and quadrupled
// - address step 1/2/4 by access size
package fld_pkg;
    localparam int unsigned INSN_W = 16;
    localparam int unsigned OP_HI = 15;
    localparam int unsigned OP_LO = 12;
    localparam int unsigned N_HI = 11;
    localparam int unsigned N_LO = 8;
    localparam int unsigned M_HI = 7;
    localparam int unsigned M_LO = 4;
    localparam int unsigned D4_HI = 3;
    localparam int unsigned D8_HI = 7;
    localparam int unsigned D12_HI = 11;
    localparam int unsigned IMM_W = 8;
    localparam int unsigned DISP_W = 12;
    localparam int unsigned TRAP_SHIFT = 2;
    localparam int unsigned TRAP_W = IMM_W + TRAP_SHIFT;
    localparam logic [2:0] STEP_NONE = 3'h0;
    localparam logic [2:0] STEP_BYTE = 3'h1;
    localparam logic [2:0] STEP_WORD = 3'h2;
    localparam logic [2:0] STEP_LONG = 3'h4;

    typedef enum logic [3:0] {
        FMT_NONE = 4'h0, FMT_ZERO = 4'h1, FMT_N = 4'h2, FMT_M = 4'h3,
        FMT_NM = 4'h4, FMT_MD = 4'h5, FMT_ND4 = 4'h6, FMT_NMD = 4'h7,
        FMT_D = 4'h8, FMT_D12 = 4'h9, FMT_ND8 = 4'ha, FMT_I = 4'hb, FMT_NI = 4'hc
    } fld_fmt_t;

    typedef enum logic [3:0] {
        MODE_NONE = 4'h0, MODE_DIRECT = 4'h1, MODE_INDIRECT = 4'h2, MODE_POSTINC = 4'h3,
        MODE_PREDEC = 4'h4, MODE_ZERO_INDEXED = 4'h5, MODE_DISP = 4'h6, MODE_GBR_DISP = 4'h7,
        MODE_PC_REL = 4'h8, MODE_CTRL_SYS = 4'h9, MODE_ACCUM = 4'ha, MODE_GBR_INDEXED = 4'hb,
        MODE_IMM = 4'hc, MODE_ZERO_REG = 4'hd
    } fld_mode_t;
endpackage

/* File: verification/fld_decoder_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fld_decoder_tb;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic slow = 1'b0;
    logic insn_valid;
    logic [15:0] insn_word;
    logic dec_valid_o, illegal_o;
    fld_pkg::fld_fmt_t fmt_o;
    fld_pkg::fld_mode_t src_mode_o, dest_mode_o;
    logic [3:0] dest_reg_o, src_reg_o;
    logic [11:0] disp_o;
    logic [31:0] imm_o;
    logic [9:0] trap_vec_o;
    logic [2:0] step_o;
    int num_errors = 0;
    int check_count = 0;
    logic [16:0] expq[$];
    logic [15:0] tpl [39] = '{16'h0009, 16'h0008, 16'h0019, 16'h0029, 16'h4003, 16'h400e, 16'h4007, 16'h402b,
        16'h300c, 16'h6006, 16'h6004, 16'h2006, 16'h2005, 16'h400f, 16'h8400, 16'h8000, 16'h1000, 16'h5000,
        16'hc600, 16'hc200, 16'hc700, 16'h8b00, 16'ha000, 16'hd000, 16'hc900, 16'hcd00, 16'hc800, 16'hcb00,
        16'hca00, 16'h8800, 16'hc300, 16'h7000, 16'he000, 16'h3001, 16'hf000, 16'h000f, 16'h4010, 16'h0004, 16'h000c};
    logic [15:0] msk [39] = '{16'h0000, 16'h0000, 16'h0000, 16'h0f00, 16'h0f00, 16'h0f00, 16'h0f00, 16'h0f00,
        16'h0ff0, 16'h0ff0, 16'h0ff0, 16'h0ff0, 16'h0ff0, 16'h0ff0, 16'h00ff, 16'h00ff, 16'h0fff, 16'h0fff,
        16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h0fff, 16'h0fff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff,
        16'h00ff, 16'h00ff, 16'h00ff, 16'h0fff, 16'h0fff, 16'h0ff0, 16'h0fff, 16'h0ff0, 16'h0f00, 16'h0ff0, 16'h0ff0};

    always #5 mclk_i = ~mclk_i;

    fld_fetch_model i_fld_fetch_model (.mclk_i(mclk_i), .reset_i(reset_i), .slow_i(slow),
        .insn_valid_o(insn_valid), .insn_o(insn_word));

    fld_decoder #(.XLEN(32)) i_fld_decoder (.mclk_i(mclk_i), .reset_i(reset_i), .insn_valid_i(insn_valid),
        .insn_i(insn_word), .dec_valid_o(dec_valid_o), .illegal_o(illegal_o), .fmt_o(fmt_o),
        .src_mode_o(src_mode_o), .dest_mode_o(dest_mode_o), .dest_reg_o(dest_reg_o), .src_reg_o(src_reg_o),
        .disp_o(disp_o), .imm_o(imm_o), .trap_vec_o(trap_vec_o), .step_o(step_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reference decode of one word taken at an edge; e = {taken, word}
    task automatic compare(input logic [16:0] e);
        logic [15:0] w;
        logic ok;
        logic [1:0] cm;
        fld_pkg::fld_fmt_t f;
        fld_pkg::fld_mode_t ms, md;
        logic [3:0] dn, sn;
        logic [11:0] d;
        logic [31:0] im;
        logic [9:0] tv;
        logic [2:0] st;
        w = e[15:0];
        ok = 1'b1;
        cm = 2'h0;
        f = fld_pkg::FMT_NONE;
        ms = fld_pkg::MODE_NONE;
        md = fld_pkg::MODE_NONE;
        dn = 4'h0;
        sn = 4'h0;
        d = 12'h000;
        im = 32'h0;
        tv = 10'h000;
        st = 3'h0;
        casez (w)
            16'h0009, 16'h0008, 16'h0019: f = fld_pkg::FMT_ZERO;
            16'h0?29, 16'h4?03:
            begin
                f = fld_pkg::FMT_N;
                dn = w[11:8];
                st = (w[15:12] == 4'h4) ? 3'h4 : 3'h0;
                cm = 2'h3;
                ms = (w[15:12] == 4'h4) ? fld_pkg::MODE_CTRL_SYS : fld_pkg::MODE_NONE;
                md = (w[15:12] == 4'h4) ? fld_pkg::MODE_PREDEC : fld_pkg::MODE_DIRECT;
            end
            16'h4?0e, 16'h4?07, 16'h4?2b:
            begin
                f = fld_pkg::FMT_M;
                sn = w[11:8];
                st = (w[3:0] == 4'h7) ? 3'h4 : 3'h0;
                cm = 2'h3;
                ms = (w[3:0] == 4'h7) ? fld_pkg::MODE_POSTINC : fld_pkg::MODE_DIRECT;
                md = (w[3:0] == 4'hb) ? fld_pkg::MODE_NONE : fld_pkg::MODE_CTRL_SYS;
            end
            16'h0??4, 16'h0??c:
            begin
                f = fld_pkg::FMT_NM;
                dn = w[11:8];
                sn = w[7:4];
                cm = 2'h3;
                ms = w[3] ? fld_pkg::MODE_ZERO_INDEXED : fld_pkg::MODE_DIRECT;
                md = w[3] ? fld_pkg::MODE_DIRECT : fld_pkg::MODE_ZERO_INDEXED;
            end
            16'h3??c, 16'h6??6, 16'h6??4, 16'h2??6, 16'h2??5, 16'h4??f:
            begin
                f = fld_pkg::FMT_NM;
                dn = w[11:8];
                sn = w[7:4];
                st = (w[15:12] == 4'h3) ? 3'h0 : (w[3:0] == 4'h4) ? 3'h1 : (w[3:0] == 4'h6) ? 3'h4 : 3'h2;
                if (w[15:12] == 4'h6 && w[3:0] == 4'h6)
                begin
                    cm = 2'h3;
                    ms = fld_pkg::MODE_POSTINC;
                    md = fld_pkg::MODE_DIRECT;
                end
                if (w[15:12] == 4'h2 && w[3:0] == 4'h6)
                begin
                    cm = 2'h2;
                    md = fld_pkg::MODE_PREDEC;
                end
                if (w[15:12] == 4'h4)
                begin
                    cm = 2'h3;
                    ms = fld_pkg::MODE_POSTINC;
                    md = fld_pkg::MODE_ACCUM;
                end
            end
            16'h84??:
            begin
                f = fld_pkg::FMT_MD;
                sn = w[7:4];
                d = {8'h00, w[3:0]};
            end
            16'h80??:
            begin
                f = fld_pkg::FMT_ND4;
                dn = w[7:4];
                d = {8'h00, w[3:0]};
            end
            16'h1???, 16'h5???:
            begin
                f = fld_pkg::FMT_NMD;
                dn = w[11:8];
                sn = w[7:4];
                d = {8'h00, w[3:0]};
            end
            16'hc6??, 16'hc2??, 16'hc7??, 16'h8b??:
            begin
                f = fld_pkg::FMT_D;
                d = {4'h0, w[7:0]};
                cm = 2'h1;
                ms = (w[15:8] == 8'hc6) ? fld_pkg::MODE_GBR_DISP
                    : (w[15:8] == 8'hc2) ? fld_pkg::MODE_ZERO_REG : fld_pkg::MODE_PC_REL;
            end
            16'ha???:
            begin
                f = fld_pkg::FMT_D12;
                d = w[11:0];
            end
            16'hd???:
            begin
                f = fld_pkg::FMT_ND8;
                dn = w[11:8];
                d = {4'h0, w[7:0]};
            end
            16'hc3??:
            begin
                f = fld_pkg::FMT_I;
                im = {24'h0, w[7:0]};
                tv = {w[7:0], 2'b00};
                cm = 2'h2;
            end
            16'hc9??, 16'hcd??, 16'hc8??, 16'hcb??, 16'hca??:
            begin
                f = fld_pkg::FMT_I;
                im = {24'h0, w[7:0]};
                cm = 2'h3;
                ms = fld_pkg::MODE_IMM;
                md = w[10] ? fld_pkg::MODE_GBR_INDEXED : fld_pkg::MODE_ZERO_REG;
            end
            16'h88??:
            begin
                f = fld_pkg::FMT_I;
                im = {{24{w[7]}}, w[7:0]};
            end
            16'h7???, 16'he???:
            begin
                f = fld_pkg::FMT_NI;
                dn = w[11:8];
                im = {{24{w[7]}}, w[7:0]};
                cm = 2'h3;
                ms = fld_pkg::MODE_IMM;
                md = fld_pkg::MODE_DIRECT;
            end
            default: ok = 1'b0;
        endcase
        if (!(e[16] && ok))
        begin
            {f, dn, sn, d, im, tv, st} = '0;
            cm = 2'h3;
            ms = fld_pkg::MODE_NONE;
            md = fld_pkg::MODE_NONE;
        end
        check(32'(dec_valid_o), 32'(e[16] & ok));
        check(32'(illegal_o), 32'(e[16] & ~ok));
        check(32'(fmt_o), 32'(f));
        check(32'(dest_reg_o), 32'(dn));
        check(32'(src_reg_o), 32'(sn));
        check(32'(disp_o), 32'(d));
        check(imm_o, im);
        check(32'(trap_vec_o), 32'(tv));
        check(32'(step_o), 32'(st));
        if (cm[0])
            check(32'(src_mode_o), 32'(ms));
        if (cm[1])
            check(32'(dest_mode_o), 32'(md));
    endtask

    always @(posedge mclk_i)
        expq.push_back({insn_valid & ~reset_i, insn_word});

    always @(negedge mclk_i)
        if (expq.size() > 0)
            compare(expq.pop_front());

    task automatic put_rand(input int n);
        int k;
        repeat (n)
        begin
            k = $urandom_range(38, 0);
            i_fld_fetch_model.put(tpl[k] | (16'($urandom) & msk[k]));
        end
    endtask

    task automatic drain(input string name);
        int t;
        t = 0;
        while (i_fld_fetch_model.pending() > 0 && t < 5000)
        begin
            @(posedge mclk_i);
            t++;
        end
        repeat (3) @(posedge mclk_i);
        $display("test %s done", name);
        if (t >= 5000)
        begin
            num_errors++;
            report_and_stop;
        end
    endtask

    initial
    begin
        void'($urandom(32'hcd56));
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        // every template with empty, full and random fields, back to back
        for (int i = 0; i < 39; i++)
        begin
            i_fld_fetch_model.put(tpl[i]);
            i_fld_fetch_model.put(tpl[i] | msk[i]);
            i_fld_fetch_model.put(tpl[i] | (16'($urandom) & msk[i]));
        end
        drain("templates");
        put_rand(400);
        drain("random back to back");
        slow <= 1'b1;
        put_rand(300);
        drain("slow fetch");
        slow <= 1'b0;
        // reset lands while words are in flight
        put_rand(40);
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        drain("reset mid stream");
        report_and_stop;
    end
endmodule
`default_nettype wire

/* File: verification/fld_fetch_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fld_fetch_model (
    input wire logic mclk_i, // processor clock
    input wire logic reset_i, // synchronous, active high
    input wire logic slow_i, // insert random fetch bubbles
    output logic insn_valid_o, // word presented
    output logic [15:0] insn_o // instruction word
);
    logic [15:0] words[$];

    task automatic put(input logic [15:0] w);
        words.push_back(w);
    endtask

    function automatic int pending();
        return words.size();
    endfunction

    initial
    begin
        insn_valid_o = 1'b0;
        insn_o = 16'h0000;
    end

    // an idle bus shows a changing pattern so stale words cannot pass as valid
    always @(posedge mclk_i)
    begin
        if (!reset_i && words.size() > 0 && !(slow_i && $urandom_range(1, 0) == 1))
        begin
            insn_valid_o <= 1'b1;
            insn_o <= words.pop_front();
        end
        else
        begin
            insn_valid_o <= 1'b0;
            insn_o <= ~insn_o;
        end
    end
endmodule
`default_nettype wire
